/* File: include/fcfg_pkg.sv */
// Purpose: Constants for the floppy configuration register bank
// Assumes: 8-bit index/data configuration access, one clock domain
// Notes:   Offsets are register indices within the floppy logical device
package fcfg_pkg;
    // Register indices
    localparam logic [7:0] IDX_MODE   = 8'hF0;   // Mode control
    localparam logic [7:0] IDX_OPTION = 8'hF1;   // Option control
    localparam logic [7:0] IDX_DTYPE  = 8'hF2;   // Drive type store
    localparam logic [7:0] IDX_RSVD   = 8'hF3;   // Reserved, reads zero
    localparam logic [7:0] IDX_DRV0   = 8'hF4;   // Drive 0 parameters
    localparam logic [7:0] IDX_DRV1   = 8'hF5;   // Drive 1 parameters
    // Reset values
    localparam logic [7:0] RST_MODE   = 8'h0E;   // Non-burst, AT mode
    localparam logic [7:0] RST_OPTION = 8'h00;   // No forcing
    localparam logic [7:0] RST_DTYPE  = 8'hFF;   // All types set
    localparam logic [7:0] RST_DRV    = 8'h00;   // Drive params default
    // Mode field positions
    localparam int MODE_ENH    = 0;              // Enhanced mode 2
    localparam int MODE_NBURST = 1;              // Non-burst DMA
    localparam int MODE_IF_LO  = 2;              // Interface mode low bit
    localparam int MODE_SWAP   = 4;              // Drive swap
    localparam int MODE_PUSHP  = 6;              // Push-pull drivers
    localparam int MODE_TRIS   = 7;              // Tri-state outputs
    // Option field positions
    localparam int OPT_FWP     = 0;              // Forced write protect
    localparam int OPT_DEN_LO  = 2;              // Density select low bit
    // Drive parameter masks and positions
    localparam logic [7:0] DRV_WMASK = 8'h5B;    // Writable bits 6,4,3,1,0
    localparam logic [7:0] MODE_WMASK = 8'hDF;   // Bit 5 reserved zero
    localparam int DRV_RT_LO   = 3;              // Rate table low bit
    localparam int DRV_PTS     = 6;              // Precomp disable
    // Interface modes
    localparam logic [1:0] IFM_AT   = 2'h3;      // AT style
    localparam logic [1:0] IFM_RSVD = 2'h2;      // Reserved
    localparam logic [1:0] IFM_ALT1 = 2'h1;      // Second compat mode
    localparam logic [1:0] IFM_ALT2 = 2'h0;      // Third compat mode
    // Density select codes
    localparam logic [1:0] DEN_FORCE1 = 2'h2;    // Force one
    localparam logic [1:0] DEN_FORCE0 = 2'h3;    // Force zero
endpackage

/* File: src/fcfg_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Inputs unrelated to core_clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module fcfg_sync #(
    parameter int          W       = 1,        // Width
    parameter logic [31:0] RST_VAL = 32'h0000_0000  // Reset level
) (
    input  wire logic         core_clk_i,  // Core clock
    input  wire logic         rst_i,       // Async reset
    input  wire logic [W-1:0] d_i,         // Raw input
    output logic      [W-1:0] q_o          // Synchronised output
);
    logic [W-1:0] meta_q;  // First stage

    // Widths beyond 32 would overrun the reset word
    if (W < 1 || W > 32) begin : g_bad_width
        $error("fcfg_sync: W out of range");
    end

    // Double-flop sample
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL[W-1:0];
            q_o    <= RST_VAL[W-1:0];
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: src/fcfg_bank.sv */
// Purpose: Floppy logical device configuration register bank
// Assumes: Config port already decoded to index/data strobes
// Notes:   Soft reset does not touch this bank; see reset inputs
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Hard resets load defaults; soft reset ignored
// - Mode at F0 resets 0E; bit0 enhanced
// - Mode bit1 set selects non-burst DMA
// - Mode bits3:2 choose interface compatibility
// - Mode bit4 swaps drive select, motor
// - Mode bit6 push-pull, clear open-drain
// - Mode bit7 tri-states all floppy outputs
// - Option F1 bit0 forces write protect
// - Write protect ORs forced, pin, disable
// - Option bits3:2 override density output
// - Type register F2 resets FF, readable
// - Index F3 reads zero always
// - Drive0 F4: type bits, rate table
// - Param bit6 disables write precompensation
// - Param bits 2,5,7 read zero
// - Drive1 F5 mirrors drive0 layout
// - DMA gate low disables irq, dma
module fcfg_bank (
    input  wire logic       core_clk_i,        // Core clock 125 MHz
    input  wire logic       rst_i,             // Async hard reset, high
    input  wire logic       vcc_por_i,         // Main supply POR, high
    input  wire logic       standby_por_i,     // Standby supply POR, high
    input  wire logic       host_bus_reset_n_i, // Host bus reset, low
    input  wire logic       soft_reset_i,      // Soft reset, ignored here
    input  wire logic [7:0] cfg_index_i,       // Selected register index
    input  wire logic       cfg_wr_i,          // Data port write strobe
    input  wire logic       cfg_rd_i,          // Data port read strobe
    input  wire logic [7:0] cfg_wdata_i,       // Write data
    output logic      [7:0] cfg_rdata_o,       // Read data, registered
    input  wire logic [1:0] core_sel_n_i,      // Core drive selects, low
    input  wire logic [1:0] core_motor_n_i,    // Core motor enables, low
    input  wire logic       core_density_i,    // Core density request
    input  wire logic       core_irq_i,        // Core interrupt
    input  wire logic       core_drq_i,        // Core DMA request
    input  wire logic       dma_gate_enable_i, // Digital output D3
    input  wire logic       core_powerdown_i,  // Core powered down
    input  wire logic       floppy_wp_bit_i,   // Device disable WP bit
    input  wire logic       write_protect_in_n_i, // Pin, async, low
    output logic [1:0]      drive_select_n_o,  // Pin out value
    output logic [1:0]      drive_select_n_oe_o, // Pin enable
    output logic [1:0]      motor_on_n_o,      // Pin out value
    output logic [1:0]      motor_on_n_oe_o,   // Pin enable
    output logic            density_o,         // Pin out value
    output logic            density_oe_o,      // Pin enable
    output logic            core_wp_n_o,       // To core and status_reg_a
    output logic            irq_o,             // Gated interrupt
    output logic            drq_o,             // Gated DMA request
    output logic            enh_mode_o,        // Enhanced mode 2
    output logic            nonburst_o,        // Non-burst DMA
    output logic [1:0]      if_mode_o,         // Interface mode
    output logic [1:0]      drive_type_sel_o,  // Active drive type
    output logic [1:0]      rate_table_sel_o,  // Active rate table
    output logic            precomp_disable_o  // Active precomp disable
);
    //////////////////////////////////////////////////////////////////////
    // Reset combine and registers
    logic       hard_rst;      // Any hard reset source
    logic       wp_pin_n;      // Synchronised write protect pin
    logic [7:0] mode_q;        // floppy_mode_ctrl
    logic [7:0] option_q;      // floppy_option_ctrl
    logic [7:0] dtype_q;       // floppy_drive_type_store
    logic [7:0] drv0_q;        // drive_zero_params
    logic [7:0] drv1_q;        // drive_one_params

    // Hard resets only
    // Soft reset deliberately not in this term
    assign hard_rst = rst_i | vcc_por_i | standby_por_i | ~host_bus_reset_n_i;

    // Write protect pin crosses into core clock
    fcfg_sync #(.W(1), .RST_VAL(32'h0000_0001)) u_wp_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .d_i        (write_protect_in_n_i),
        .q_o        (wp_pin_n)
    );

    // Masked write helper
    function automatic logic [7:0] wmask(input logic [7:0] d, input logic [7:0] m);
        return d & m;
    endfunction

    //////////////////////////////////////////////////////////////////////
    // Mode register store
    // Reserved bit 5 kept zero
    always_ff @(posedge core_clk_i or posedge hard_rst) begin
        if (hard_rst) begin
            mode_q <= fcfg_pkg::RST_MODE;
        end else if (cfg_wr_i && cfg_index_i == fcfg_pkg::IDX_MODE) begin
            mode_q <= wmask(cfg_wdata_i, fcfg_pkg::MODE_WMASK);
        end
    end

    always_ff @(posedge core_clk_i or posedge hard_rst) begin
        if (hard_rst) begin
            option_q <= fcfg_pkg::RST_OPTION;
        end else if (cfg_wr_i && cfg_index_i == fcfg_pkg::IDX_OPTION) begin
            option_q <= cfg_wdata_i;
        end
    end

    // Drive type store, all bits kept
    always_ff @(posedge core_clk_i or posedge hard_rst) begin
        if (hard_rst) begin
            dtype_q <= fcfg_pkg::RST_DTYPE;
        end else if (cfg_wr_i && cfg_index_i == fcfg_pkg::IDX_DTYPE) begin
            dtype_q <= cfg_wdata_i;
        end
    end

    // Read-only bits forced zero on write
    // Drive 1 uses the same layout
    always_ff @(posedge core_clk_i or posedge hard_rst) begin
        if (hard_rst) begin
            drv0_q <= fcfg_pkg::RST_DRV;
            drv1_q <= fcfg_pkg::RST_DRV;
        end else if (cfg_wr_i) begin
            if (cfg_index_i == fcfg_pkg::IDX_DRV0) begin
                drv0_q <= wmask(cfg_wdata_i, fcfg_pkg::DRV_WMASK);
            end
            if (cfg_index_i == fcfg_pkg::IDX_DRV1) begin
                drv1_q <= wmask(cfg_wdata_i, fcfg_pkg::DRV_WMASK);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Read back, one cycle after the strobe
    always_ff @(posedge core_clk_i or posedge hard_rst) begin
        if (hard_rst) begin
            cfg_rdata_o <= 8'h00;
        end else if (cfg_rd_i) begin
            case (cfg_index_i)
                fcfg_pkg::IDX_MODE:   cfg_rdata_o <= mode_q;
                fcfg_pkg::IDX_OPTION: cfg_rdata_o <= option_q;
                fcfg_pkg::IDX_DTYPE:  cfg_rdata_o <= dtype_q;
                fcfg_pkg::IDX_RSVD:   cfg_rdata_o <= 8'h00;
                fcfg_pkg::IDX_DRV0:   cfg_rdata_o <= drv0_q;
                fcfg_pkg::IDX_DRV1:   cfg_rdata_o <= drv1_q;
                // Unmapped indices read zero
                default:              cfg_rdata_o <= 8'h00;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Pin side
    logic       swap;        // Swap enabled
    logic [1:0] sel_pin_n;   // Selects after swap
    logic [1:0] mot_pin_n;   // Motors after swap
    logic [1:0] den_code;    // Density select code
    logic       den_val;     // Density value to drive
    logic       wp_forced;   // Forced term
    logic [7:0] act_prm;     // Parameters of active drive

    assign swap = mode_q[fcfg_pkg::MODE_SWAP];
    // Exchange drive 0 and drive 1 pins
    assign sel_pin_n = swap ? {core_sel_n_i[0], core_sel_n_i[1]} : core_sel_n_i;
    assign mot_pin_n = swap ? {core_motor_n_i[0], core_motor_n_i[1]} : core_motor_n_i;

    assign den_code = option_q[fcfg_pkg::OPT_DEN_LO +: 2];
    assign den_val  = (den_code == fcfg_pkg::DEN_FORCE1) ? 1'b1 :
                      (den_code == fcfg_pkg::DEN_FORCE0) ? 1'b0 : core_density_i;

    // Forced active while any drive selected
    // Selects are active low, so selected means a zero
    assign wp_forced = option_q[fcfg_pkg::OPT_FWP] & (~core_sel_n_i[0] | ~core_sel_n_i[1]);

    // Pin-level drive 0 is the swapped one
    assign act_prm = (~sel_pin_n[1] & sel_pin_n[0]) ? drv1_q : drv0_q;

    // Output drivers: value and enable per pin
    // Open-drain only enables when pulling low
    always_ff @(posedge core_clk_i or posedge hard_rst) begin
        if (hard_rst) begin
            drive_select_n_o    <= 2'h3;
            motor_on_n_o        <= 2'h3;
            density_o           <= 1'b0;
            drive_select_n_oe_o <= 2'h0;
            motor_on_n_oe_o     <= 2'h0;
            density_oe_o        <= 1'b0;
        end else begin
            drive_select_n_o <= sel_pin_n;
            motor_on_n_o     <= mot_pin_n;
            density_o        <= den_val;
            if (mode_q[fcfg_pkg::MODE_TRIS]) begin
                drive_select_n_oe_o <= 2'h0;
                motor_on_n_oe_o     <= 2'h0;
                density_oe_o        <= 1'b0;
            end else if (mode_q[fcfg_pkg::MODE_PUSHP]) begin
                drive_select_n_oe_o <= 2'h3;
                motor_on_n_oe_o     <= 2'h3;
                density_oe_o        <= 1'b1;
            end else begin
                drive_select_n_oe_o <= ~sel_pin_n;
                motor_on_n_oe_o     <= ~mot_pin_n;
                density_oe_o        <= ~den_val;
            end
        end
    end

    // Write protect OR of three sources
    // Active low result: protect when any source asks
    always_ff @(posedge core_clk_i or posedge hard_rst) begin
        if (hard_rst) begin
            core_wp_n_o <= 1'b1;
        end else begin
            core_wp_n_o <= ~(wp_forced | ~wp_pin_n | floppy_wp_bit_i);
        end
    end

    always_ff @(posedge core_clk_i or posedge hard_rst) begin
        if (hard_rst) begin
            irq_o <= 1'b0;
            drq_o <= 1'b0;
        end else begin
            irq_o <= core_irq_i & dma_gate_enable_i & ~core_powerdown_i;
            drq_o <= core_drq_i & dma_gate_enable_i & ~core_powerdown_i;
        end
    end

    // Mode and active drive settings to the core
    // Non-burst select
    // Interface mode passed whole; reserved code left to core
    always_ff @(posedge core_clk_i or posedge hard_rst) begin
        if (hard_rst) begin
            enh_mode_o        <= 1'b0;
            nonburst_o        <= 1'b1;
            if_mode_o         <= fcfg_pkg::IFM_AT;
            drive_type_sel_o  <= 2'h0;
            rate_table_sel_o  <= 2'h0;
            precomp_disable_o <= 1'b0;
        end else begin
            enh_mode_o        <= mode_q[fcfg_pkg::MODE_ENH];
            nonburst_o        <= mode_q[fcfg_pkg::MODE_NBURST];
            if_mode_o         <= mode_q[fcfg_pkg::MODE_IF_LO +: 2];
            drive_type_sel_o  <= act_prm[1:0];
            rate_table_sel_o  <= act_prm[fcfg_pkg::DRV_RT_LO +: 2];
            precomp_disable_o <= act_prm[fcfg_pkg::DRV_PTS];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Assertions
    mode_reset_a: assert property (@(posedge core_clk_i)
        $fell(hard_rst) |-> mode_q == fcfg_pkg::RST_MODE)
        else $error("mode register not at reset value");
    gate_irq_a: assert property (@(posedge core_clk_i) disable iff (hard_rst)
        !dma_gate_enable_i |=> !irq_o && !drq_o)
        else $error("irq or drq passed with gate closed");
    tris_oe_a: assert property (@(posedge core_clk_i) disable iff (hard_rst)
        mode_q[fcfg_pkg::MODE_TRIS] |=> drive_select_n_oe_o == 2'h0 && !density_oe_o)
        else $error("output driven while tri-stated");
    pushpull_oe_a: assert property (@(posedge core_clk_i) disable iff (hard_rst)
        mode_q[7:6] == 2'b01 |=> motor_on_n_oe_o == 2'h3)
        else $error("push-pull enable not asserted");
    swap_pins_a: assert property (@(posedge core_clk_i) disable iff (hard_rst)
        swap |=> drive_select_n_o == {$past(core_sel_n_i[0]), $past(core_sel_n_i[1])})
        else $error("drive selects not swapped");
    density_force_a: assert property (@(posedge core_clk_i) disable iff (hard_rst)
        den_code == fcfg_pkg::DEN_FORCE0 |=> !density_o)
        else $error("density not forced low");
    wp_force_a: assert property (@(posedge core_clk_i) disable iff (hard_rst)
        option_q[0] && core_sel_n_i != 2'h3 |=> !core_wp_n_o)
        else $error("write protect not forced");
    rsvd_read_a: assert property (@(posedge core_clk_i) disable iff (hard_rst)
        cfg_rd_i && cfg_index_i == fcfg_pkg::IDX_RSVD |=> cfg_rdata_o == 8'h00)
        else $error("reserved slot read nonzero");
    drv_ro_a: assert property (@(posedge core_clk_i) disable iff (hard_rst)
        ((drv0_q | drv1_q) & 8'hA4) == 8'h00)
        else $error("read-only parameter bit set");
    soft_ignore_a: assert property (@(posedge core_clk_i) disable iff (hard_rst)
        soft_reset_i && !cfg_wr_i |=> $stable(mode_q) && $stable(dtype_q))
        else $error("soft reset changed bank");
    cv_swap: cover property (@(posedge core_clk_i) swap && !core_sel_n_i[0]);
    cv_tris: cover property (@(posedge core_clk_i) mode_q[fcfg_pkg::MODE_TRIS]);
    cv_drv1: cover property (@(posedge core_clk_i) cfg_wr_i && cfg_index_i == fcfg_pkg::IDX_DRV1);
endmodule
`default_nettype wire

/* File: verif/fcfg_drive_model.sv */
// Purpose: Floppy cable side model: resolves drive pins and makes the protect pin
// Assumes: Every floppy line carries a pull-up on the cable side
// Notes:   A released line reads the pull-up level, never its last value
`timescale 1ns/1ps
`default_nettype none
module fcfg_drive_model (
    input  wire logic [1:0] sel_val_i,  // Select pin value
    input  wire logic [1:0] sel_oe_i,   // Select pin enable
    input  wire logic [1:0] mtr_val_i,  // Motor pin value
    input  wire logic [1:0] mtr_oe_i,   // Motor pin enable
    input  wire logic       den_val_i,  // Density pin value
    input  wire logic       den_oe_i,   // Density pin enable
    input  wire logic       wp_req_i,   // Disk protected when high
    output logic      [1:0] sel_wire_o, // Resolved select lines
    output logic      [1:0] mtr_wire_o, // Resolved motor lines
    output logic            den_wire_o, // Resolved density line
    output logic            wp_n_o      // Protect pin, active low
);
    //////////////////////////////////////////////////////////////////////////
    // Line resolution: undriven lines go to the pull-up level
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            sel_wire_o[i] = sel_oe_i[i] ? sel_val_i[i] : 1'b1;
            mtr_wire_o[i] = mtr_oe_i[i] ? mtr_val_i[i] : 1'b1;
        end
        den_wire_o = den_oe_i ? den_val_i : 1'b1;
        wp_n_o     = ~wp_req_i;
    end
endmodule
`default_nettype wire

/* File: verif/test_floppy_logical_device_config.sv */
// Purpose: Self-checking bench for the floppy configuration bank
// Assumes: Index already latched; data port reached by one-cycle strobes
// Notes:   Inputs change 1 ns after the rising edge; outputs lag registers
`timescale 1ns/1ps
`default_nettype none
module test_floppy_logical_device_config;
    logic       clk, rst, vpor, spor, hbr_n, srst;   // Clock and reset sources
    logic [7:0] index, wdata, rdata;                 // Config port
    logic       cfg_wr, cfg_rd;                      // Data port strobes
    logic [1:0] csel, cmtr, sel_v, sel_oe, mtr_v, mtr_oe, swire, mwire; // Drive lines
    logic       cden, cirq, cdrq, gate, pd, fwp, wpreq, wp_n; // Core side levels
    logic       den_v, den_oe, dwire, core_wp_n, irq, drq;   // Pin and gated outputs
    logic       enh, nonburst, pdis;                 // Mode outputs
    logic [1:0] ifm, dtype, rtab;                    // Mode and active params
    int         checks, miscompares;                 // Result counters
    localparam logic [7:0] IDXS [7] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'h10};
    localparam logic [7:0] EXPS [7] = '{8'hDF, 8'hFF, 8'hFF, 8'h00, 8'h5B, 8'h5B, 8'h00};

    fcfg_bank uut (.core_clk_i(clk), .rst_i(rst), .vcc_por_i(vpor), .standby_por_i(spor),
        .host_bus_reset_n_i(hbr_n), .soft_reset_i(srst), .cfg_index_i(index),
        .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
        .core_sel_n_i(csel), .core_motor_n_i(cmtr), .core_density_i(cden),
        .core_irq_i(cirq), .core_drq_i(cdrq), .dma_gate_enable_i(gate),
        .core_powerdown_i(pd), .floppy_wp_bit_i(fwp), .write_protect_in_n_i(wp_n),
        .drive_select_n_o(sel_v), .drive_select_n_oe_o(sel_oe), .motor_on_n_o(mtr_v),
        .motor_on_n_oe_o(mtr_oe), .density_o(den_v), .density_oe_o(den_oe),
        .core_wp_n_o(core_wp_n), .irq_o(irq), .drq_o(drq), .enh_mode_o(enh),
        .nonburst_o(nonburst), .if_mode_o(ifm), .drive_type_sel_o(dtype),
        .rate_table_sel_o(rtab), .precomp_disable_o(pdis));

    fcfg_drive_model drv (.sel_val_i(sel_v), .sel_oe_i(sel_oe), .mtr_val_i(mtr_v),
        .mtr_oe_i(mtr_oe), .den_val_i(den_v), .den_oe_i(den_oe), .wp_req_i(wpreq),
        .sel_wire_o(swire), .mtr_wire_o(mwire), .den_wire_o(dwire), .wp_n_o(wp_n));

    //////////////////////////////////////////////////////////////////////////
    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    //////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Host data port write, strobe held for exactly one edge
    // Index then data
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        #1;
        index = idx;
        wdata = d;
        cfg_wr = 1'b1;
        @(posedge clk);
        #1;
        cfg_wr = 1'b0;
    endtask

    // Host data port read; data is registered one edge after the strobe
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge clk);
        #1;
        index = idx;
        cfg_rd = 1'b1;
        @(posedge clk);
        #1;
        cfg_rd = 1'b0;
        chk(rdata, exp);
    endtask

    // Let register and pin stages land; also covers the 3-flop protect path
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #200_000;
        miscompares++;
        report_and_stop();
    end

    //////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        checks = 0;
        miscompares = 0;
        {rst, vpor, spor, hbr_n, srst} = 5'b10010;
        {index, wdata, cfg_wr, cfg_rd} = '0;
        {csel, cmtr} = 4'hF;
        {cden, cirq, cdrq, gate, pd, fwp, wpreq} = '0;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        // Defaults after reset
        rd_chk(fcfg_pkg::IDX_MODE, 8'h0E);
        rd_chk(fcfg_pkg::IDX_OPTION, 8'h00);
        rd_chk(fcfg_pkg::IDX_DTYPE, 8'hFF);
        rd_chk(fcfg_pkg::IDX_RSVD, 8'h00);
        rd_chk(fcfg_pkg::IDX_DRV0, 8'h00);
        rd_chk(fcfg_pkg::IDX_DRV1, 8'h00);
        chk(8'({nonburst, ifm, enh}), 8'h0E);
        // Write all ones then all zeros; read-only bits stay zero
        for (int i = 0; i < 7; i++) begin
            wr(IDXS[i], 8'hFF);
            rd_chk(IDXS[i], EXPS[i]);
            wr(IDXS[i], 8'h00);
            rd_chk(IDXS[i], 8'h00);
        end
        // Every interface mode code, with enhanced mode and burst DMA
        for (int m = 0; m < 4; m++) begin
            wr(fcfg_pkg::IDX_MODE, {4'h0, 2'(m), 2'b01});
            settle();
            chk(8'({enh, nonburst, ifm}), 8'({2'b10, 2'(m)}));
        end
        // Drive 0 selected and running, then swap and driver styles
        csel = 2'b10;
        cmtr = 2'b10;
        wr(fcfg_pkg::IDX_MODE, 8'h0E);
        settle();
        chk(8'({enh, nonburst}), 8'h01);
        chk(8'({sel_v, sel_oe, mwire}), 8'h26);
        wr(fcfg_pkg::IDX_MODE, 8'h1E);
        settle();
        chk(8'({swire, mtr_v}), 8'h05);
        wr(fcfg_pkg::IDX_MODE, 8'h5E);
        settle();
        chk(8'({sel_oe, mtr_oe, swire}), 8'h3D);
        wr(fcfg_pkg::IDX_MODE, 8'hDE);
        settle();
        chk(8'({sel_oe, mtr_oe, den_oe, swire, dwire}), 8'h07);
        // Density override codes with both core requests, push-pull drivers
        wr(fcfg_pkg::IDX_MODE, 8'h4E);
        for (int c = 0; c < 8; c++) begin
            cden = c[0];
            wr(fcfg_pkg::IDX_OPTION, {4'h0, 2'(c >> 1), 2'b00});
            settle();
            chk(8'(den_v), (c >> 1) == 2 ? 8'h01 : (c >> 1) == 3 ? 8'h00 : 8'(c[0]));
        end
        // Write protect sources, one at a time
        wr(fcfg_pkg::IDX_OPTION, 8'h01);
        csel = 2'b11;
        settle();
        chk(8'(core_wp_n), 8'h01);
        csel = 2'b01;
        settle();
        chk(8'(core_wp_n), 8'h00);
        wr(fcfg_pkg::IDX_OPTION, 8'h00);
        settle();
        chk(8'(core_wp_n), 8'h01);
        fwp = 1'b1;
        settle();
        chk(8'(core_wp_n), 8'h00);
        fwp = 1'b0;
        wpreq = 1'b1;
        settle();
        chk(8'(core_wp_n), 8'h00);
        wpreq = 1'b0;
        // Interrupt and DMA gating by gate bit and power-down
        {cirq, cdrq, gate} = 3'b111;
        settle();
        chk(8'({irq, drq}), 8'h03);
        gate = 1'b0;
        settle();
        chk(8'({irq, drq}), 8'h00);
        {gate, pd} = 2'b11;
        settle();
        chk(8'({irq, drq}), 8'h00);
        pd = 1'b0;
        // Active drive parameters follow the selected pin after swap
        wr(fcfg_pkg::IDX_DRV0, 8'h09);
        wr(fcfg_pkg::IDX_DRV1, 8'h52);
        csel = 2'b10;
        settle();
        chk(8'({pdis, rtab, dtype}), 8'h05);
        csel = 2'b01;
        settle();
        chk(8'({pdis, rtab, dtype}), 8'h1A);
        csel = 2'b10;
        wr(fcfg_pkg::IDX_MODE, 8'h1E);
        settle();
        chk(8'({pdis, rtab, dtype}), 8'h1A);
        // Soft reset keeps the bank; each hard source restores defaults
        for (int s = 0; s < 4; s++) begin
            wr(fcfg_pkg::IDX_MODE, 8'h51);
            wr(fcfg_pkg::IDX_DTYPE, 8'h00);
            case (s)
                0: srst = 1'b1;
                1: vpor = 1'b1;
                2: spor = 1'b1;
                default: hbr_n = 1'b0;
            endcase
            repeat (2) @(posedge clk);
            #1;
            {srst, vpor, spor, hbr_n} = 4'b0001;
            rd_chk(fcfg_pkg::IDX_MODE, s == 0 ? 8'h51 : 8'h0E);
            rd_chk(fcfg_pkg::IDX_DTYPE, s == 0 ? 8'h00 : 8'hFF);
            rd_chk(fcfg_pkg::IDX_DRV1, s == 0 ? 8'h52 : 8'h00);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
